// ---- hdl/poe_i2c_pkg.sv ----
package poe_i2c_pkg;
	////////////////////////////////////////////////////////////////////////
	// Client addresses
	localparam logic [6:0] ADDR_SEL_LOW = 7'h20;
	localparam logic [6:0] ADDR_SEL_HIGH = 7'h21;
	localparam logic [6:0] ADDR_BROADCAST = 7'h00;
	////////////////////////////////////////////////////////////////////////
	// Register offsets
	localparam logic [7:0] OFS_PORT_POWER_CONFIG = 8'h00;
	localparam logic [7:0] OFS_PORT_VOLTAGE_LOW = 8'h02;
	localparam logic [7:0] OFS_PORT_VOLTAGE_HIGH = 8'h03;
	////////////////////////////////////////////////////////////////////////
	// Field positions and reset values
	localparam int MODE_LSB = 0;
	localparam int MODE_MSB = 2;
	localparam int RSVD_BIT = 3;
	localparam int ALT_LSB = 4;
	localparam int ALT_MSB = 6;
	localparam int VHI_DATA_MSB = 1;
	localparam int VHI_VALID_BIT = 2;
	localparam logic [6:0] CONFIG_RESET = 7'h00;
	localparam int VOLT_BITS = 10;
	////////////////////////////////////////////////////////////////////////
	// Power modes
	typedef enum logic [2:0] {
		MODE_STD = 3'h0,
		MODE_LIM110 = 3'h1,
		MODE_LIM195 = 3'h2,
		MODE_LIM280 = 3'h3,
		MODE_LIM485 = 3'h4,
		MODE_LIM607 = 3'h5,
		MODE_UNDEF = 3'h6,
		MODE_HIGH = 3'h7
	} power_mode_t;
	////////////////////////////////////////////////////////////////////////
	// Currents in mA
	localparam logic [9:0] CUT_STD_MA = 10'd375;
	localparam logic [9:0] LIM_STD_MA = 10'd425;
	localparam logic [9:0] LIM_110_MA = 10'd110;
	localparam logic [9:0] LIM_195_MA = 10'd195;
	localparam logic [9:0] LIM_280_MA = 10'd280;
	localparam logic [9:0] LIM_485_MA = 10'd485;
	localparam logic [9:0] LIM_607_MA = 10'd607;
	localparam logic [9:0] CUT_HIGH_MA = 10'd642;
	localparam logic [9:0] LIM_HIGH_MA = 10'd720;
	localparam logic [9:0] CURRENT_NONE = 10'd0;
	////////////////////////////////////////////////////////////////////////
	// Voltage scale, microvolts per code step
	localparam int VOLT_LSB_UV = 58600;
	////////////////////////////////////////////////////////////////////////
	// Timing
	localparam int CLK_KHZ = 100000;
	localparam int WATCHDOG_MS = 500;
	localparam int WATCHDOG_CYCLES = WATCHDOG_MS * CLK_KHZ;
	localparam int REFRESH_MS = 1;
	localparam int REFRESH_CYCLES = REFRESH_MS * CLK_KHZ;
	////////////////////////////////////////////////////////////////////////
	// Serial port states
	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_ADDR = 4'h1,
		ST_ADDR_ACK = 4'h2,
		ST_REG = 4'h3,
		ST_W_ACK = 4'h4,
		ST_WDATA = 4'h5,
		ST_RDATA = 4'h6,
		ST_R_ACK = 4'h7
	} port_state_t;
endpackage

// ---- hdl/port_voltage_capture.sv ----
`timescale 1ns/10ps
module port_voltage_capture #(
	parameter int REFRESH_CYCLES = poe_i2c_pkg::REFRESH_CYCLES
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// Conversion input
	input wire logic [9:0] voltage_sample,
	// Read strobes
	input wire logic read_low,
	input wire logic read_high,
	// Register contents
	output logic [7:0] port_voltage_low_byte,
	output logic [1:0] high_bits,
	output logic valid
);
	logic [31:0] tick_cnt;
	logic [9:0] live;
	wire tick = (tick_cnt == 32'(REFRESH_CYCLES - 1));

	assign port_voltage_low_byte = live[7:0];

	////////////////////////////////////////////////////////////////////////
	// Refresh divider
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			tick_cnt <= 32'h0;
		end else if (tick) begin
			tick_cnt <= 32'h0;
		end else begin
			tick_cnt <= tick_cnt + 32'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sample, snapshot and valid flag
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			live <= 10'h000;
			high_bits <= 2'h0;
			valid <= 1'b0;
		end else begin
			if (tick) begin
				live <= voltage_sample;
			end
			if (read_low) begin
				high_bits <= live[9:8];
			end
			if (tick) begin
				valid <= 1'b1;
			end else if (read_high) begin
				valid <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);

	property p_refresh;
		tick |=> valid && port_voltage_low_byte == $past(voltage_sample[7:0]);
	endproperty
	a_refresh: assert property (p_refresh) else $error("voltage not refreshed");

	property p_valid_clear;
		read_high && !tick |=> !valid;
	endproperty
	a_valid_clear: assert property (p_valid_clear) else $error("valid not cleared");

	property p_snapshot;
		read_low && !tick ##1 !tick[*2] |-> high_bits == live[9:8];
	endproperty
	a_snapshot: assert property (p_snapshot) else $error("high bits not paired");
endmodule

// ---- hdl/poe_port_i2c_register_port.sv ----
`timescale 1ns/10ps
// Operation
// - Answer at 0x20 or 0x21 per select pin
// - Only the select pin picks the address
// - Client only, never drives the clock
// - Works from standstill up to 100 kbps
// - Also answer broadcast address 0x00, for writes only
// - Reset port after 0.5 s clock stall
// - Never stretch the serial clock
// - Mode code 0 to 3 sets limits
// - Mode codes 4, 5, 7 set limits
// - Pair-set field loads from mode resistor
// - Voltage low byte refreshed every 1 ms
// - Voltage code is linear, 58.6 mV steps
// - Ten-bit voltage, top bits at 0x03
// - Valid flag set on sample, cleared by reading 0x03
module poe_port_i2c_register_port #(
	parameter int WATCHDOG_CYCLES = poe_i2c_pkg::WATCHDOG_CYCLES,
	parameter int REFRESH_CYCLES = poe_i2c_pkg::REFRESH_CYCLES
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// Serial bus
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// Straps and measurements
	input wire logic addr_select,
	input wire logic [2:0] mode_resistor_input,
	input wire logic [9:0] voltage_sample,
	// Power settings
	output logic [9:0] overload_cutoff_current,
	output logic [9:0] current_limit_level,
	output logic cutoff_enable,
	output logic pair_set_a,
	output logic pair_set_b,
	output logic pair_set_cap
);
	poe_i2c_pkg::port_state_t state;
	logic scl_q, sda_q, rw, nack, strap_done;
	logic [3:0] bitcnt;
	logic [7:0] shift, pointer;
	logic [6:0] port_power_config;
	logic [31:0] wd_cnt;
	logic read_low, read_high;
	logic [7:0] vlow;
	logic [1:0] vhigh;
	logic vvalid;

	////////////////////////////////////////////////////////////////////////
	// Bus decode
	wire scl_rise = scl_in && !scl_q;
	wire scl_fall = !scl_in && scl_q;
	wire start_cond = scl_in && scl_q && sda_q && !sda_in;
	wire stop_cond = scl_in && scl_q && !sda_q && sda_in;
	wire [6:0] own_addr = addr_select ? poe_i2c_pkg::ADDR_SEL_HIGH :
		poe_i2c_pkg::ADDR_SEL_LOW;
	wire is_own = shift[7:1] == own_addr;
	wire is_bcast = shift[7:1] == poe_i2c_pkg::ADDR_BROADCAST && !shift[0];
	wire addr_match = is_own || is_bcast;
	wire byte_done = scl_fall && bitcnt == 4'h8;
	wire busy = state != poe_i2c_pkg::ST_IDLE;
	wire wd_fire = busy && wd_cnt == 32'(WATCHDOG_CYCLES - 1);
	wire load_rd = scl_fall && ((state == poe_i2c_pkg::ST_ADDR_ACK && rw) ||
		(state == poe_i2c_pkg::ST_R_ACK && !nack));
	wire [7:0] rd_byte = pointer == poe_i2c_pkg::OFS_PORT_POWER_CONFIG ?
		{1'b0, port_power_config} :
		pointer == poe_i2c_pkg::OFS_PORT_VOLTAGE_LOW ? vlow :
		pointer == poe_i2c_pkg::OFS_PORT_VOLTAGE_HIGH ? {5'h00, vvalid, vhigh} : 8'h00;
	wire cfg_write = byte_done && state == poe_i2c_pkg::ST_WDATA &&
		pointer == poe_i2c_pkg::OFS_PORT_POWER_CONFIG;
	wire [2:0] mode = port_power_config[poe_i2c_pkg::MODE_MSB:poe_i2c_pkg::MODE_LSB];
	wire [2:0] alt = port_power_config[poe_i2c_pkg::ALT_MSB:poe_i2c_pkg::ALT_LSB];

	assign read_low = load_rd && pointer == poe_i2c_pkg::OFS_PORT_VOLTAGE_LOW;
	assign read_high = load_rd && pointer == poe_i2c_pkg::OFS_PORT_VOLTAGE_HIGH;

	////////////////////////////////////////////////////////////////////////
	// Mode to current decode, {cutoff_en, cutoff, limit}
	function automatic logic [20:0] mode_currents(input logic [2:0] m);
		case (m)
			poe_i2c_pkg::MODE_STD:
				mode_currents = {1'b1, poe_i2c_pkg::CUT_STD_MA, poe_i2c_pkg::LIM_STD_MA};
			poe_i2c_pkg::MODE_LIM110:
				mode_currents = {1'b0, poe_i2c_pkg::CURRENT_NONE, poe_i2c_pkg::LIM_110_MA};
			poe_i2c_pkg::MODE_LIM195:
				mode_currents = {1'b0, poe_i2c_pkg::CURRENT_NONE, poe_i2c_pkg::LIM_195_MA};
			poe_i2c_pkg::MODE_LIM280:
				mode_currents = {1'b0, poe_i2c_pkg::CURRENT_NONE, poe_i2c_pkg::LIM_280_MA};
			poe_i2c_pkg::MODE_LIM485:
				mode_currents = {1'b0, poe_i2c_pkg::CURRENT_NONE, poe_i2c_pkg::LIM_485_MA};
			poe_i2c_pkg::MODE_LIM607:
				mode_currents = {1'b0, poe_i2c_pkg::CURRENT_NONE, poe_i2c_pkg::LIM_607_MA};
			poe_i2c_pkg::MODE_HIGH:
				mode_currents = {1'b1, poe_i2c_pkg::CUT_HIGH_MA, poe_i2c_pkg::LIM_HIGH_MA};
			default:
				mode_currents = {1'b0, poe_i2c_pkg::CURRENT_NONE, poe_i2c_pkg::CURRENT_NONE};
		endcase
	endfunction

	wire [20:0] next_currents = mode_currents(mode);

	////////////////////////////////////////////////////////////////////////
	// Voltage sampling
	port_voltage_capture #(
		.REFRESH_CYCLES(REFRESH_CYCLES)
	) u_capture (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.voltage_sample(voltage_sample),
		.read_low(read_low),
		.read_high(read_high),
		.port_voltage_low_byte(vlow),
		.high_bits(vhigh),
		.valid(vvalid)
	);

	////////////////////////////////////////////////////////////////////////
	// Configuration register and outputs
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			port_power_config <= poe_i2c_pkg::CONFIG_RESET;
			strap_done <= 1'b0;
		end else if (!strap_done) begin
			strap_done <= 1'b1;
			port_power_config[poe_i2c_pkg::ALT_MSB:poe_i2c_pkg::ALT_LSB] <=
				mode_resistor_input;
		end else if (cfg_write) begin
			port_power_config <= shift[6:0];
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			cutoff_enable <= 1'b0;
			overload_cutoff_current <= 10'h000;
			current_limit_level <= 10'h000;
			pair_set_a <= 1'b0;
			pair_set_b <= 1'b0;
			pair_set_cap <= 1'b0;
		end else begin
			{cutoff_enable, overload_cutoff_current, current_limit_level} <= next_currents;
			pair_set_a <= alt == 3'h2 || alt == 3'h3;
			pair_set_b <= alt == 3'h0 || alt == 3'h1;
			pair_set_cap <= (alt == 3'h1 || alt == 3'h3);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Watchdog, restarted by every clock edge
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			wd_cnt <= 32'h0;
		end else if (!busy || scl_rise || scl_fall || wd_fire) begin
			wd_cnt <= 32'h0;
		end else begin
			wd_cnt <= wd_cnt + 32'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Serial client; the clock is only ever sampled
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			sda_out <= 1'b0;
			sda_oe <= 1'b0;
			state <= poe_i2c_pkg::ST_IDLE;
			bitcnt <= 4'h0;
			shift <= 8'h00;
			pointer <= 8'h00;
			rw <= 1'b0;
			nack <= 1'b0;
		end else begin
			scl_q <= scl_in;
			sda_q <= sda_in;
			if (wd_fire || stop_cond) begin
				state <= poe_i2c_pkg::ST_IDLE;
				sda_oe <= 1'b0;
			end else if (start_cond) begin
				state <= poe_i2c_pkg::ST_ADDR;
				bitcnt <= 4'h0;
				sda_oe <= 1'b0;
			end else begin
				case (state)
					poe_i2c_pkg::ST_ADDR, poe_i2c_pkg::ST_REG, poe_i2c_pkg::ST_WDATA: begin
						if (scl_rise) begin
							shift <= {shift[6:0], sda_in};
							bitcnt <= bitcnt + 4'h1;
						end else if (byte_done) begin
							bitcnt <= 4'h0;
							if (state == poe_i2c_pkg::ST_ADDR) begin
								sda_oe <= addr_match;
								rw <= shift[0];
								state <= addr_match ? poe_i2c_pkg::ST_ADDR_ACK :
									poe_i2c_pkg::ST_IDLE;
							end else begin
								sda_oe <= 1'b1;
								state <= poe_i2c_pkg::ST_W_ACK;
								pointer <= state == poe_i2c_pkg::ST_REG ? shift :
									pointer + 8'h01;
							end
						end
					end
					poe_i2c_pkg::ST_ADDR_ACK, poe_i2c_pkg::ST_R_ACK: begin
						if (scl_rise) begin
							nack <= sda_in;
						end else if (load_rd) begin
							shift <= {rd_byte[6:0], 1'b0};
							sda_oe <= !rd_byte[7];
							pointer <= pointer + 8'h01;
							bitcnt <= 4'h0;
							state <= poe_i2c_pkg::ST_RDATA;
						end else if (scl_fall) begin
							sda_oe <= 1'b0;
							state <= state == poe_i2c_pkg::ST_ADDR_ACK ?
								poe_i2c_pkg::ST_REG : poe_i2c_pkg::ST_IDLE;
						end
					end
					poe_i2c_pkg::ST_W_ACK: begin
						if (scl_fall) begin
							sda_oe <= 1'b0;
							state <= poe_i2c_pkg::ST_WDATA;
						end
					end
					poe_i2c_pkg::ST_RDATA: begin
						if (scl_fall && bitcnt == 4'h7) begin
							sda_oe <= 1'b0;
							nack <= 1'b0;
							state <= poe_i2c_pkg::ST_R_ACK;
						end else if (scl_fall) begin
							sda_oe <= !shift[7];
							shift <= {shift[6:0], 1'b0};
							bitcnt <= bitcnt + 4'h1;
						end
					end
					default: begin
						sda_oe <= 1'b0;
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);

	sequence s_addr_end;
		state == poe_i2c_pkg::ST_ADDR && byte_done && !start_cond && !stop_cond && !wd_fire;
	endsequence

	property p_ack_own;
		s_addr_end and is_own |=> sda_oe ##0
			state == poe_i2c_pkg::ST_ADDR_ACK;
	endproperty
	a_ack_own: assert property (p_ack_own) else $error("own address not acknowledged");

	property p_sel_pin;
		s_addr_end and (shift[7:1] == poe_i2c_pkg::ADDR_SEL_HIGH && !addr_select) |=> !sda_oe;
	endproperty
	a_sel_pin: assert property (p_sel_pin) else $error("address not set by pin");

	property p_bcast;
		s_addr_end and (shift == 8'h00) |=> sda_oe;
	endproperty
	a_bcast: assert property (p_bcast) else $error("broadcast not acknowledged");

	property p_watchdog;
		wd_fire |=> state == poe_i2c_pkg::ST_IDLE && !sda_oe;
	endproperty
	a_watchdog: assert property (p_watchdog) else $error("watchdog did not reset port");

	property p_no_stretch;
		$rose(sda_oe) |-> !scl_in;
	endproperty
	a_no_stretch: assert property (p_no_stretch) else $error("sda driven with clock high");

	property p_mode_std;
		mode == 3'h0 ##1 mode == 3'h0 |-> current_limit_level == poe_i2c_pkg::LIM_STD_MA &&
			overload_cutoff_current == poe_i2c_pkg::CUT_STD_MA && cutoff_enable;
	endproperty
	a_mode_std: assert property (p_mode_std) else $error("standard limits wrong");

	property p_mode_high;
		mode == 3'h7 ##1 mode == 3'h7 |-> current_limit_level == poe_i2c_pkg::LIM_HIGH_MA &&
			overload_cutoff_current == poe_i2c_pkg::CUT_HIGH_MA && cutoff_enable;
	endproperty
	a_mode_high: assert property (p_mode_high) else $error("high-power limits wrong");

	property p_strap;
		$rose(strap_done) |-> alt == $past(mode_resistor_input);
	endproperty
	a_strap: assert property (p_strap) else $error("pair-set field not loaded");
endmodule

// ---- tb/i2c_host.sv ----
`timescale 1ns/10ps
module i2c_host (
	// Clock
	input wire logic sys_clk,
	// Serial bus
	input wire logic dev_sda_oe,
	output logic scl,
	output logic sda
);
	logic host_oe = 1'b0;
	int half = 500;
	// Open-drain wire with pull-up
	assign sda = !(host_oe | dev_sda_oe);
	initial begin
		scl = 1'b1;
	end
	task automatic hw(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic start();
		host_oe = 1'b0;
		hw(half);
		scl = 1'b1;
		hw(half);
		host_oe = 1'b1;
		hw(half);
		scl = 1'b0;
	endtask
	task automatic stop();
		host_oe = 1'b1;
		hw(half);
		scl = 1'b1;
		hw(half);
		host_oe = 1'b0;
		hw(half);
	endtask
	task automatic put_bit(input logic b);
		host_oe = !b;
		hw(half);
		scl = 1'b1;
		hw(half);
		scl = 1'b0;
	endtask
	task automatic get_bit(output logic b);
		host_oe = 1'b0;
		hw(half);
		scl = 1'b1;
		hw(half);
		b = sda;
		scl = 1'b0;
	endtask
	task automatic write_byte(input logic [7:0] d, output logic ack);
		logic b;
		for (int i = 7; i >= 0; i--) begin
			put_bit(d[i]);
		end
		get_bit(b);
		ack = !b;
	endtask
	task automatic read_byte(input logic last, output logic [7:0] d);
		for (int i = 7; i >= 0; i--) begin
			get_bit(d[i]);
		end
		put_bit(last);
	endtask
endmodule

// ---- tb/poe_port_i2c_register_port_test.sv ----
`timescale 1ns/10ps
module poe_port_i2c_register_port_test;
	logic sys_clk = 1'b0;
	logic rst_b = 1'b0;
	logic addr_select = 1'b0;
	logic [2:0] mode_resistor_input = 3'h3;
	logic [9:0] voltage_sample = 10'h000;
	logic scl, sda, sda_out, sda_oe, cut_en, p_a, p_b, p_cap;
	logic [9:0] cut, lim;
	int n_fail = 0;
	int comparisons = 0;
	int cycles = 0;
	always #5 sys_clk = ~sys_clk;
	poe_port_i2c_register_port #(.WATCHDOG_CYCLES(2000), .REFRESH_CYCLES(50))
		poe_port_i2c_register_port_inst (.sys_clk(sys_clk), .rst_b(rst_b), .scl_in(scl),
		.sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .addr_select(addr_select),
		.mode_resistor_input(mode_resistor_input), .voltage_sample(voltage_sample),
		.overload_cutoff_current(cut), .current_limit_level(lim), .cutoff_enable(cut_en),
		.pair_set_a(p_a), .pair_set_b(p_b), .pair_set_cap(p_cap));
	i2c_host i2c_host_inst (.sys_clk(sys_clk), .dev_sda_oe(sda_oe), .scl(scl), .sda(sda));
	////////////////////////////////////////////////////////////////////////
	task automatic complete_run();
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 95000) begin
			n_fail++;
			complete_run();
		end
	end
	task automatic check(input string name, input logic [9:0] exp, got);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic check_mode(input logic [2:0] m, input logic [1:0] alt);
		logic [9:0] l, c;
		c = poe_i2c_pkg::CURRENT_NONE;
		case (m)
			3'h0: begin
				l = poe_i2c_pkg::LIM_STD_MA;
				c = poe_i2c_pkg::CUT_STD_MA;
			end
			3'h1: l = poe_i2c_pkg::LIM_110_MA;
			3'h2: l = poe_i2c_pkg::LIM_195_MA;
			3'h3: l = poe_i2c_pkg::LIM_280_MA;
			3'h4: l = poe_i2c_pkg::LIM_485_MA;
			3'h5: l = poe_i2c_pkg::LIM_607_MA;
			default: begin
				l = poe_i2c_pkg::LIM_HIGH_MA;
				c = poe_i2c_pkg::CUT_HIGH_MA;
			end
		endcase
		check("limit", l, lim);
		check("cutoff", c, cut);
		check("cut_en", {9'h000, m == 3'h0 || m == 3'h7}, {9'h000, cut_en});
		check("pairs", {7'h00, alt[1], !alt[1], alt[0]}, {7'h00, p_a, p_b, p_cap});
	endtask
	task automatic reg_write(input logic [6:0] a, input logic [7:0] p, d, output logic ack);
		logic k;
		i2c_host_inst.start();
		i2c_host_inst.write_byte({a, 1'b0}, ack);
		i2c_host_inst.write_byte(p, k);
		i2c_host_inst.write_byte(d, k);
		i2c_host_inst.stop();
	endtask
	task automatic reg_read2(input logic [6:0] a, input logic [7:0] p, output logic [7:0] d0, d1);
		logic k;
		i2c_host_inst.start();
		i2c_host_inst.write_byte({a, 1'b0}, k);
		i2c_host_inst.write_byte(p, k);
		i2c_host_inst.start();
		i2c_host_inst.write_byte({a, 1'b1}, k);
		i2c_host_inst.read_byte(1'b0, d0);
		i2c_host_inst.read_byte(1'b1, d1);
		i2c_host_inst.stop();
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic test_modes();
		logic ack;
		logic [7:0] d0, d1;
		for (int i = 0; i < 8; i++) begin
			if (i != 6) begin
				reg_write(poe_i2c_pkg::ADDR_SEL_LOW, poe_i2c_pkg::OFS_PORT_POWER_CONFIG,
					{2'h0, 2'(i), 1'b0, 3'(i)}, ack);
				i2c_host_inst.half = 50;
				check("ack", 10'h001, {9'h000, ack});
				check_mode(3'(i), 2'(i));
			end
		end
		reg_read2(poe_i2c_pkg::ADDR_SEL_LOW, poe_i2c_pkg::OFS_PORT_POWER_CONFIG, d0, d1);
		check("config", 10'h037, {2'h0, d0});
		check("unmapped", 10'h000, {2'h0, d1});
	endtask
	task automatic test_address();
		logic ack;
		reg_write(poe_i2c_pkg::ADDR_SEL_HIGH, poe_i2c_pkg::OFS_PORT_POWER_CONFIG, 8'h02, ack);
		check("pin_low", 10'h000, {9'h000, ack});
		check_mode(3'h7, 2'h3);
		addr_select = 1'b1;
		reg_write(poe_i2c_pkg::ADDR_SEL_LOW, poe_i2c_pkg::OFS_PORT_POWER_CONFIG, 8'h01, ack);
		check("old_addr", 10'h000, {9'h000, ack});
		check_mode(3'h7, 2'h3);
		reg_write(poe_i2c_pkg::ADDR_SEL_HIGH, poe_i2c_pkg::OFS_PORT_POWER_CONFIG, 8'h01, ack);
		check("new_addr", 10'h001, {9'h000, ack});
		check_mode(3'h1, 2'h0);
	endtask
	task automatic test_broadcast();
		logic ack;
		reg_write(poe_i2c_pkg::ADDR_BROADCAST, poe_i2c_pkg::OFS_PORT_POWER_CONFIG, 8'h05, ack);
		check("bc_ack", 10'h001, {9'h000, ack});
		check_mode(3'h5, 2'h0);
		i2c_host_inst.start();
		i2c_host_inst.write_byte({poe_i2c_pkg::ADDR_BROADCAST, 1'b1}, ack);
		i2c_host_inst.stop();
		check("bc_read", 10'h000, {9'h000, ack});
	endtask
	task automatic test_voltage();
		logic [7:0] d0, d1;
		logic [9:0] vs [2] = '{10'h2A5, 10'h15A};
		for (int i = 0; i < 2; i++) begin
			voltage_sample = vs[i];
			i2c_host_inst.hw(60);
			reg_read2(poe_i2c_pkg::ADDR_SEL_HIGH, poe_i2c_pkg::OFS_PORT_VOLTAGE_LOW, d0, d1);
			check("volt_lo", {2'h0, vs[i][7:0]}, {2'h0, d0});
			check("volt_hi", {7'h01, vs[i][9:8]}, {2'h0, d1});
		end
	endtask
	task automatic test_watchdog();
		logic ack;
		logic [7:0] a;
		a = {poe_i2c_pkg::ADDR_SEL_HIGH, 1'b0};
		i2c_host_inst.start();
		for (int i = 7; i >= 0; i--) begin
			i2c_host_inst.put_bit(a[i]);
		end
		i2c_host_inst.host_oe = 1'b0;
		i2c_host_inst.hw(5);
		check("ack_held", 10'h001, {9'h000, sda_oe});
		i2c_host_inst.hw(2100);
		check("wd_free", 10'h000, {9'h000, sda_oe});
		i2c_host_inst.stop();
		reg_write(poe_i2c_pkg::ADDR_SEL_HIGH, poe_i2c_pkg::OFS_PORT_POWER_CONFIG, 8'h04, ack);
		check("wd_ack", 10'h001, {9'h000, ack});
		check_mode(3'h4, 2'h0);
		check("sda_out", 10'h000, {9'h000, sda_out});
	endtask
	task automatic test_strap();
		mode_resistor_input = 3'h1;
		rst_b = 1'b0;
		i2c_host_inst.hw(3);
		rst_b = 1'b1;
		i2c_host_inst.hw(3);
		check_mode(3'h0, 2'h1);
	endtask
	initial begin
		repeat (3) @(posedge sys_clk);
		#1;
		rst_b = 1'b1;
		i2c_host_inst.hw(3);
		check_mode(3'h0, 2'h3);
		test_modes();
		test_address();
		test_broadcast();
		test_voltage();
		test_watchdog();
		test_strap();
		complete_run();
	end
endmodule
